// [hdl/errq_map.svh]
// Constants for the error queue and command fault classifier
`ifndef ERRQ_MAP_SVH
`define ERRQ_MAP_SVH
`define ERRQ_DEPTH        20
`define ERRQ_MSG_MAX      80
`define ERRQ_HDR_MAX      12
`define ERRQ_SHORT_MAX    4
`define ERR_NONE          16'sh0000
`define ERR_INV_CHAR      16'shFF9B
`define ERR_SYNTAX        16'shFF9A
`define ERR_SEPARATOR     16'shFF99
`define ERR_DATA_TYPE     16'shFF98
`define ERR_GET_INSIDE    16'shFF97
`define ERR_PARM_EXTRA    16'shFF94
`define ERR_PARM_MISSING  16'shFF93
`define ERR_HDR_LONG      16'shFF90
`define ERR_HDR_UNDEF     16'shFF8F
`define ERR_OVERFLOW      16'shFEA2
`endif

// [hdl/errq_pkg.sv]
// Types shared by the error queue block
package errq_pkg;
  typedef logic signed [15:0] err_code_t;

  // Fault flags raised by the command parser for one command
  typedef struct packed {
    logic inv_char;
    logic syntax;
    logic separator;
    logic data_type;
    logic get_inside;
    logic parm_extra;
    logic parm_missing;
    logic hdr_long;
    logic hdr_undef;
  } fault_t;

  // Answer to one read of the queue
  typedef struct packed {
    err_code_t code;
    logic      empty;
  } answer_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CMD   = 2'b01,
    ST_FLUSH = 2'b10
  } parse_st_t;
endpackage

// [hdl/error_queue_core.sv]
// Error classifier, error queue, indicator and beep of the command interpreter
// Behaviour
// - Errors are kept in a queue of at most twenty entries.
// - Each generated error gives one beep pulse, stored or not.
// - Reads return the oldest stored error first.
// - Error indicator is on while the queue holds anything.
// - Error into a full queue replaces newest entry with overflow code.
// - After overflow, new errors are dropped until a read removes one.
// - Empty read answers code zero remotely, no-errors flag on panel.
// - Queue empties at power-up and on clear-status command.
// - Reset common command leaves the queue untouched.
// - Each remote error query removes and returns one entry.
// - Answer is signed code plus message length of at most eighty characters.
// - Header longer than twelve characters logs code -112.
// - Forbidden character in keyword or parameter logs code -101.
// - Malformed syntax such as stray whitespace logs code -102.
// - Wrong separator logs code -103.
// - Wrong parameter type logs code -104.
// - Group execute trigger inside a command string logs code -105.
// - Too many parameters logs code -108.
// - Missing required parameters logs code -109.
// - Unknown header, or short form over four letters, logs code -113.
// - Each panel error-key press without a same-cycle remote query pops and shows one queued error.
// - Device clear flushes buffers and restarts parser, queue kept.
`include "errq_map.svh"
`timescale 1ns/100ps
`default_nettype none

module error_queue_core
  import errq_pkg::*;
#(
  parameter int DEPTH    = `ERRQ_DEPTH,
  parameter int HDR_MAX  = `ERRQ_HDR_MAX,
  parameter int SHORT_MAX = `ERRQ_SHORT_MAX
) (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       NRST,
  // Parsed command report
  input  wire logic       CMD_DONE,
  input  wire logic [7:0] HDR_LEN,
  input  wire logic [7:0] SHORT_LEN,
  input  wire logic       SHORT_FORM,
  input  wire fault_t     FAULTS,
  // Other error sources
  input  wire logic       EXT_ERR,
  input  wire err_code_t  EXT_CODE,
  // Common commands and interface messages
  input  wire logic       CLS_CMD,
  input  wire logic       RST_CMD,
  input  wire logic       DEV_CLEAR,
  // Readers
  input  wire logic       REMOTE_RD,
  input  wire logic       PANEL_KEY,
  // Answers
  output logic            RD_VALID,
  output err_code_t       RD_CODE,
  output logic            RD_PANEL,
  output logic            RD_EMPTY,
  output logic [6:0]      RD_MSG_LEN,
  // Indicators
  output logic            ERR_LAMP,
  output logic            BEEP,
  output logic            FLUSH_BUFS,
  output logic            PARSER_READY,
  output logic [4:0]      ERR_COUNT
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || DEPTH > 31) $error("DEPTH out of range");
    if (HDR_MAX < 1 || HDR_MAX > 255) $error("HDR_MAX out of range");
    if (SHORT_MAX < 1 || SHORT_MAX > 255) $error("SHORT_MAX out of range");
    if (`ERRQ_MSG_MAX > 127) $error("message length does not fit its field");
    if ($bits(err_code_t) != 16) $error("error code must be 16 bits");
  end

  // Queue storage
  err_code_t        mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [4:0]       count;
  logic             overflowed;
  parse_st_t        state;

  // Classified error of this cycle
  logic             new_err;
  err_code_t        new_code;
  logic             cmd_err;
  err_code_t        cmd_code;
  logic             hdr_too_long;
  logic             short_too_long;

  // Read and store decisions
  logic             do_read;
  logic             pop;
  logic [4:0]       count_after_rd;
  logic             has_room;
  logic             locked;
  logic             store;
  logic             replace;

  // Queue head, newest slot, next answer and next parser state
  err_code_t        head_code;
  logic [AW-1:0]    newest;
  answer_t          next_answer;
  parse_st_t        next_state;

  // Wrap-around pointer step
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      ptr_inc = '0;
    end else begin
      ptr_inc = p + AW'(1);
    end
  endfunction

  // Pointer step backwards, for the newest entry
  function automatic logic [AW-1:0] ptr_dec(input logic [AW-1:0] p);
    if (p == '0) begin
      ptr_dec = AW'(DEPTH - 1);
    end else begin
      ptr_dec = p - AW'(1);
    end
  endfunction

  // Message length for a code, longest text kept within eighty characters
  function automatic logic [6:0] msg_len(input err_code_t c);
    case (c)
      `ERR_NONE:         msg_len = 7'd8;
      `ERR_INV_CHAR:     msg_len = 7'd17;
      `ERR_SYNTAX:       msg_len = 7'd12;
      `ERR_SEPARATOR:    msg_len = 7'd17;
      `ERR_DATA_TYPE:    msg_len = 7'd15;
      `ERR_GET_INSIDE:   msg_len = 7'd15;
      `ERR_PARM_EXTRA:   msg_len = 7'd21;
      `ERR_PARM_MISSING: msg_len = 7'd17;
      `ERR_HDR_LONG:     msg_len = 7'd25;
      `ERR_HDR_UNDEF:    msg_len = 7'd16;
      `ERR_OVERFLOW:     msg_len = 7'd14;
      default:           msg_len = 7'(`ERRQ_MSG_MAX);
    endcase
  endfunction

  // Priority encoder of parser faults into one code, first fault wins
  function automatic err_code_t classify(input fault_t f, input logic hdr_long,
                                         input logic short_long);
    if (f.get_inside) begin
      classify = `ERR_GET_INSIDE;
    end else if (f.inv_char) begin
      classify = `ERR_INV_CHAR;
    end else if (f.syntax) begin
      classify = `ERR_SYNTAX;
    end else if (f.separator) begin
      classify = `ERR_SEPARATOR;
    end else if (hdr_long) begin
      classify = `ERR_HDR_LONG;
    end else if (f.hdr_undef || short_long) begin
      classify = `ERR_HDR_UNDEF;
    end else if (f.data_type) begin
      classify = `ERR_DATA_TYPE;
    end else if (f.parm_extra) begin
      classify = `ERR_PARM_EXTRA;
    end else if (f.parm_missing) begin
      classify = `ERR_PARM_MISSING;
    end else begin
      classify = `ERR_NONE;
    end
  endfunction

  // Length checks on the received header
  always_comb begin
    hdr_too_long   = FAULTS.hdr_long || HDR_LEN > 8'(HDR_MAX);
    short_too_long = SHORT_FORM && SHORT_LEN > 8'(SHORT_MAX);
  end

  // One error per cycle: a faulty command, else the other source
  always_comb begin
    cmd_code = classify(FAULTS, hdr_too_long, short_too_long);
    cmd_err  = CMD_DONE && state == ST_CMD && cmd_code != `ERR_NONE;
    if (cmd_err) begin
      new_err  = 1'b1;
      new_code = cmd_code;
    end else begin
      new_err  = EXT_ERR;
      new_code = EXT_CODE;
    end
  end

  // Oldest entry and slot of the newest entry
  assign head_code = mem[rd_ptr];
  assign newest    = ptr_dec(wr_ptr);

  // Read request; one pop even when both readers ask together
  always_comb begin
    do_read = REMOTE_RD || PANEL_KEY;
    pop     = do_read && count != 5'd0;
  end

  // Count after the read of this cycle, before any store
  always_comb begin
    count_after_rd = pop ? count - 5'd1 : count;
  end

  // Room left after the read, and the overflow lock
  always_comb begin
    has_room = count_after_rd < 5'(DEPTH);
    locked   = overflowed && !pop;
  end

  // Store or overflow decision; clear-status drops the new error
  always_comb begin
    store   = new_err && !CLS_CMD && has_room && !locked;
    replace = new_err && !CLS_CMD && !has_room && !overflowed;
  end

  // Next parser state: device clear flushes and restarts, queue kept
  always_comb begin
    case (state)
      ST_IDLE:  next_state = ST_CMD;
      ST_CMD:   next_state = DEV_CLEAR ? ST_FLUSH : ST_CMD;
      ST_FLUSH: next_state = ST_CMD;
      default:  next_state = ST_IDLE;
    endcase
  end

  // Parser state register
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Storage writes; overflow code replaces the newest entry
  always_ff @(posedge MCLK) begin
    if (store) begin
      mem[wr_ptr] <= new_code;
    end else if (replace) begin
      mem[newest] <= `ERR_OVERFLOW;
    end
  end

  // Read pointer; reset and clear-status empty the queue
  always_ff @(posedge MCLK) begin
    if (!NRST || CLS_CMD) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= ptr_inc(rd_ptr);
    end
  end

  // Write pointer, advanced only by a stored error
  always_ff @(posedge MCLK) begin
    if (!NRST || CLS_CMD) begin
      wr_ptr <= '0;
    end else if (store) begin
      wr_ptr <= ptr_inc(wr_ptr);
    end
  end

  // Entry count: removal first, then the store decision
  always_ff @(posedge MCLK) begin
    if (!NRST || CLS_CMD) begin
      count <= 5'd0;
    end else begin
      count <= count_after_rd + (store ? 5'd1 : 5'd0);
    end
  end

  // Overflow lock until an entry is removed
  always_ff @(posedge MCLK) begin
    if (!NRST || CLS_CMD) begin
      overflowed <= 1'b0;
    end else if (replace) begin
      overflowed <= 1'b1;
    end else if (pop) begin
      overflowed <= 1'b0;
    end
  end

  // Answer of this read: oldest entry, or zero and the empty flag
  always_comb begin
    if (pop) begin
      next_answer.code  = head_code;
      next_answer.empty = 1'b0;
    end else begin
      next_answer.code  = `ERR_NONE;
      next_answer.empty = 1'b1;
    end
  end

  // Answer strobe, one cycle after each read
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= do_read;
    end
  end

  // Answer flags: who asked and whether the queue was empty
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      RD_PANEL <= 1'b0;
      RD_EMPTY <= 1'b0;
    end else if (do_read) begin
      RD_PANEL <= !REMOTE_RD;
      RD_EMPTY <= next_answer.empty;
    end
  end

  // Answer code and message length, held until the next read
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      RD_CODE    <= `ERR_NONE;
      RD_MSG_LEN <= 7'd0;
    end else if (do_read) begin
      RD_CODE    <= next_answer.code;
      RD_MSG_LEN <= msg_len(next_answer.code);
    end
  end

  // Beep pulse for every generated error
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      BEEP <= 1'b0;
    end else begin
      BEEP <= new_err;
    end
  end

  // Flush pulse for the input/output buffers
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      FLUSH_BUFS <= 1'b0;
    end else begin
      FLUSH_BUFS <= state == ST_CMD && DEV_CLEAR;
    end
  end

  // Parser ready level for the command source
  assign PARSER_READY = state == ST_CMD;

  // Error indicator and count, straight from the count register
  assign ERR_LAMP     = count != 5'd0;
  assign ERR_COUNT    = count;

endmodule

`default_nettype wire

// [verif/error_queue_core_chk.sv]
// Assertion checker for the error queue core
`timescale 1ns/100ps
`default_nettype none
module error_queue_core_chk
  import errq_pkg::*;
(
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       NRST,
  // Requests
  input wire logic       EXT_ERR,
  input wire logic       CLS_CMD,
  input wire logic       DEV_CLEAR,
  input wire logic       REMOTE_RD,
  input wire logic       PANEL_KEY,
  // Answers and indicators
  input wire logic       RD_VALID,
  input wire err_code_t  RD_CODE,
  input wire logic       RD_EMPTY,
  input wire logic [6:0] RD_MSG_LEN,
  input wire logic       ERR_LAMP,
  input wire logic       BEEP,
  input wire logic       FLUSH_BUFS,
  input wire logic       PARSER_READY,
  input wire logic [4:0] ERR_COUNT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // Read request and its one-cycle answer
  sequence read_req; REMOTE_RD || PANEL_KEY; endsequence
  sequence answer; RD_VALID ##0 (RD_MSG_LEN <= 7'h50); endsequence
  AST_BEEP: assert property (EXT_ERR |=> BEEP)
    else $error("no beep after error");
  AST_LAMP: assert property (ERR_LAMP == (ERR_COUNT != 5'h00))
    else $error("lamp disagrees with count");
  AST_DEPTH: assert property (ERR_COUNT <= 5'h14)
    else $error("count above depth");
  AST_READ: assert property (read_req |=> answer)
    else $error("read not answered");
  AST_EMPTY: assert property (RD_VALID && RD_EMPTY |-> RD_CODE == 16'sh0000)
    else $error("empty answer not zero");
  AST_NONE: assert property (read_req ##0 ERR_COUNT == 5'h00 |=> RD_EMPTY)
    else $error("empty read not flagged");
  AST_CLS: assert property (CLS_CMD |=> ERR_COUNT == 5'h00)
    else $error("clear status kept entries");
  AST_DCL: assert property (DEV_CLEAR && PARSER_READY |=> FLUSH_BUFS)
    else $error("no flush after device clear");
endmodule
bind error_queue_core error_queue_core_chk i_chk (.MCLK(MCLK), .NRST(NRST), .EXT_ERR(EXT_ERR),
  .CLS_CMD(CLS_CMD), .DEV_CLEAR(DEV_CLEAR), .REMOTE_RD(REMOTE_RD), .PANEL_KEY(PANEL_KEY),
  .RD_VALID(RD_VALID), .RD_CODE(RD_CODE), .RD_EMPTY(RD_EMPTY), .RD_MSG_LEN(RD_MSG_LEN),
  .ERR_LAMP(ERR_LAMP), .BEEP(BEEP), .FLUSH_BUFS(FLUSH_BUFS), .PARSER_READY(PARSER_READY),
  .ERR_COUNT(ERR_COUNT));
`default_nettype wire

// [verif/host_model.sv]
// Host controller model delivering parsed command reports
`timescale 1ns/100ps
`default_nettype none
module host_model
  import errq_pkg::*;
(
  // Clock
  input  wire logic  MCLK,
  // Command report
  output logic       CMD_DONE = 1'b0,
  output logic [7:0] HDR_LEN = 8'h00,
  output logic [7:0] SHORT_LEN = 8'h00,
  output logic       SHORT_FORM = 1'b0,
  output fault_t     FAULTS = '0
);
  // One report held for one edge, then the fields are scrambled
  task automatic send(input fault_t f, input logic [7:0] hl, input logic [7:0] sl,
                      input logic sf);
    @(posedge MCLK);
    #1;
    CMD_DONE = 1'b1;
    FAULTS = f;
    HDR_LEN = hl;
    SHORT_LEN = sl;
    SHORT_FORM = sf;
    @(posedge MCLK);
    #1;
    CMD_DONE = 1'b0;
    FAULTS = ~f;
    HDR_LEN = ~hl;
    SHORT_LEN = ~sl;
    SHORT_FORM = ~sf;
  endtask
endmodule
`default_nettype wire

// [verif/error_queue_core_test.sv]
// Self-checking bench for the error queue core
`timescale 1ns/100ps
`default_nettype none
module error_queue_core_test;
  import errq_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, ext = 1'b0, cls = 1'b0, rst = 1'b0;
  logic dcl = 1'b0, rrd = 1'b0, pkey = 1'b0;
  err_code_t ext_code = 16'sh0000;
  logic cmd_done, sform, rd_valid, rd_panel, rd_empty, lamp, beep, flush, ready;
  logic [7:0] hlen, slen;
  fault_t faults;
  err_code_t rd_code;
  logic [6:0] msg_len;
  logic [4:0] count;
  int mismatches = 0;
  int comparisons = 0;
  // Clock and parts
  initial begin
    forever #4 mclk = ~mclk;
  end
  host_model i_host (.MCLK(mclk), .CMD_DONE(cmd_done), .HDR_LEN(hlen), .SHORT_LEN(slen),
    .SHORT_FORM(sform), .FAULTS(faults));
  error_queue_core i_dut (.MCLK(mclk), .NRST(nrst), .CMD_DONE(cmd_done), .HDR_LEN(hlen),
    .SHORT_LEN(slen), .SHORT_FORM(sform), .FAULTS(faults), .EXT_ERR(ext), .EXT_CODE(ext_code),
    .CLS_CMD(cls), .RST_CMD(rst), .DEV_CLEAR(dcl), .REMOTE_RD(rrd), .PANEL_KEY(pkey),
    .RD_VALID(rd_valid), .RD_CODE(rd_code), .RD_PANEL(rd_panel), .RD_EMPTY(rd_empty),
    .RD_MSG_LEN(msg_len), .ERR_LAMP(lamp), .BEEP(beep), .FLUSH_BUFS(flush),
    .PARSER_READY(ready), .ERR_COUNT(count));
  task tick;
    @(posedge mclk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Error from the other source, one cycle
  task automatic err(input logic [15:0] c);
    ext_code = c;
    ext = 1'b1;
    tick;
    ext = 1'b0;
    chk(16'(beep), 16'h0001);
    tick;
  endtask
  // Remote or panel read of one entry
  task automatic rd(input logic p, input logic [15:0] exp);
    rrd = !p;
    pkey = p;
    tick;
    rrd = 1'b0;
    pkey = 1'b0;
    chk(rd_code, exp);
    chk(16'(rd_valid), 16'h0001);
    tick;
  endtask
  // Every fault kind in turn, then read back in order
  task automatic t_codes;
    logic [15:0] codes [10];
    codes = '{16'hFF9B, 16'hFF9A, 16'hFF99, 16'hFF98, 16'hFF97, 16'hFF94, 16'hFF93,
              16'hFF90, 16'hFF8F, 16'hFF8F};
    for (int i = 0; i < 11; i++) begin
      for (int w = 0; w < 20 && ready !== 1'b1; w++) tick;
      if (ready !== 1'b1) begin
        mismatches++;
        results;
      end
      i_host.send((i < 7 || i == 8) ? fault_t'(9'h100 >> i) : '0, (i == 7) ? 8'h0D : 8'h0C,
                  (i == 9) ? 8'h05 : 8'h04, i >= 9);
    end
    chk(16'(count), 16'h000A);
    for (int i = 0; i < 10; i++) rd(i[0], codes[i]);
    chk(16'(lamp), 16'h0000);
  endtask
  // Overflow, drop, refill, an empty read and clear status
  task automatic t_ovf;
    for (int i = 1; i < 23; i++) err(i[15:0]);
    chk(16'(count), 16'h0014);
    rd(1'b0, 16'h0001);
    err(16'h0077);
    chk(16'(count), 16'h0014);
    for (int i = 2; i < 20; i++) rd(1'b0, i[15:0]);
    rd(1'b0, 16'hFEA2);
    rd(1'b0, 16'h0077);
    rd(1'b1, 16'h0000);
    chk(16'({rd_empty, rd_panel}), 16'h0003);
    err(16'h0005);
    ext = 1'b1;
    cls = 1'b1;
    tick;
    ext = 1'b0;
    cls = 1'b0;
    chk(16'(count), 16'h0000);
    tick;
  endtask
  // Reset command, device clear, read beside a new error
  task automatic t_keep;
    err(16'h0033);
    rst = 1'b1;
    tick;
    rst = 1'b0;
    dcl = 1'b1;
    tick;
    dcl = 1'b0;
    chk(16'(count), 16'h0001);
    ext_code = 16'h0044;
    ext = 1'b1;
    rrd = 1'b1;
    tick;
    ext = 1'b0;
    rrd = 1'b0;
    chk(rd_code, 16'h0033);
    tick;
    rd(1'b0, 16'h0044);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    nrst = 1'b1;
    tick;
    t_codes;
    t_ovf;
    t_keep;
    results;
  end
endmodule
`default_nettype wire
